// ===== tb.sv
// Self-checking bench for the temperature conversion sequencer
`timescale 1ns/100ps
`default_nettype none

module tb;
   import tcs_pkg::*;

   localparam int INTERVAL = 400;
   localparam int WINDOW   = 64;

   logic         clock_in;
   logic         rstn_in;
   logic         standby;
   logic         cmd;
   logic [3:0]   trim;
   tcs_temp_t    temp_set;
   tcs_temp_t    level;
   tcs_fan_cfg_s cfg;
   tcs_temp_t    result;
   tcs_bytes_s   bytes;
   logic         upd;
   logic         converting;
   logic         stby_seen;
   logic [7:0]   fan_target;
   logic [7:0]   fan_drive;
   int           fails = 0;
   int           n_tests = 0;
   int           cyc = 0;
   int           t0;

   tcs_diode_model u_tcs_diode_model
   (
      .clock_in  (clock_in),
      .temp_in   (temp_set),
      .level_out (level)
   );

   tcs_sequencer #(.INTERVAL_CYCLES(INTERVAL), .WINDOW_CYCLES(WINDOW))
   u_tcs_sequencer
   (
      .clock_in                     (clock_in),
      .rstn_in                      (rstn_in),
      .standby_in                   (standby),
      .single_conversion_command_in (cmd),
      .gain_trim_in                 (trim),
      .adc_level_in                 (level),
      .fan_cfg_in                   (cfg),
      .temp_result_out              (result),
      .temp_bytes_out               (bytes),
      .result_update_out            (upd),
      .converting_out               (converting),
      .standby_out                  (stby_seen),
      .fan_target_out               (fan_target),
      .fan_drive_out                (fan_drive)
   );

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   task stop_test();
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Run-length guard
   always @(posedge clock_in)
   begin
      cyc <= cyc + 1;
      if (cyc >= 5000)
      begin
         fails = fails + 1;
         stop_test();
      end
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         fails = fails + 1;
      end
   endtask

   task wait_upd();
      int k;
      k = 0;
      while (upd !== 1'b1 && k < 2000)
      begin
         @(posedge clock_in);
         #1;
         k = k + 1;
      end
   endtask

   task t_reset();
      #1;
      chk(16'(result), 16'h0000);
      chk(16'(bytes), 16'h0000);
      chk(16'({stby_seen, converting, upd, fan_drive}), 16'h0000);
      $display("test reset done");
   endtask

   task t_freerun();
      wait_upd();
      t0 = cyc;
      @(posedge clock_in);
      #1;
      wait_upd();
      chk(16'(cyc - t0), 16'(INTERVAL));
      chk(16'(fan_drive), 16'h005A);
      $display("test free run done");
   endtask

   // Command conversion; a second command lands mid-conversion
   task conv(input tcs_temp_t lvl, input logic [3:0] tr,
             input tcs_temp_t exp);
      tcs_temp_t old;
      int        n;
      old = result;
      @(posedge clock_in);
      temp_set <= lvl;
      trim     <= tr;
      @(posedge clock_in);
      cmd <= 1'b1;
      @(posedge clock_in);
      cmd <= 1'b0;
      #1;
      t0 = cyc;
      @(posedge clock_in);
      cmd <= 1'b1;
      #1;
      chk(16'(converting), 16'h0001);
      chk(16'(result), 16'(old));
      @(posedge clock_in);
      cmd <= 1'b0;
      wait_upd();
      n = cyc - t0;
      chk(16'(n >= WINDOW + 1 && n <= WINDOW + 2), 16'h0001);
      chk(16'(result), 16'(exp));
      chk(bytes, {exp[10:3], exp[2:0], 5'h00});
      $display("test conversion done");
   endtask

   task t_abort();
      tcs_temp_t old;
      int        seen;
      old  = result;
      seen = 0;
      @(posedge clock_in);
      temp_set <= 11'sh190;
      trim     <= 4'h8;
      cmd      <= 1'b1;
      @(posedge clock_in);
      cmd <= 1'b0;
      repeat (8) @(posedge clock_in);
      standby <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1;
      chk(16'(converting), 16'h0000);
      chk(16'(fan_drive), 16'h0000);
      chk(16'(fan_target), 16'h005A);
      chk(16'(stby_seen), 16'h0001);
      repeat (WINDOW + 8)
      begin
         @(posedge clock_in);
         #1;
         if (upd === 1'b1)
            seen = seen + 1;
      end
      chk(16'(seen), 16'h0000);
      chk(16'(result), 16'(old));
      $display("test standby abort done");
   endtask

   task t_standby_exit();
      @(posedge clock_in);
      temp_set <= 11'sh100;
      standby  <= 1'b0;
      #1;
      t0 = cyc;
      wait_upd();
      chk(16'(cyc - t0 >= INTERVAL + WINDOW - 1 &&
              cyc - t0 <= INTERVAL + WINDOW + 4), 16'h0001);
      chk(16'(result), 16'h0100);
      chk(16'(stby_seen), 16'h0000);
      $display("test standby exit done");
   endtask

   task t_fan();
      @(posedge clock_in);
      cfg.thermal_open <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      chk({fan_target, fan_drive}, 16'h6060);
      @(posedge clock_in);
      cfg.range_shift <= 3'h7;
      cfg.speed_open  <= 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
      chk({fan_target, fan_drive}, 16'hFF33);
      @(posedge clock_in);
      cfg.threshold  <= 8'sh28;
      cfg.speed_open <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      chk({fan_target, fan_drive}, 16'h0000);
      @(posedge clock_in);
      cfg.thermal_open <= 1'b1;
      cfg.speed_open   <= 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
      chk({fan_target, fan_drive}, 16'h5A33);
      $display("test fan done");
   endtask

   initial
   begin
      rstn_in  = 1'b0;
      standby  = 1'b0;
      cmd      = 1'b0;
      trim     = 4'h8;
      temp_set = 11'sh100;
      cfg      = '{8'sh14, 3'h2, 1'b1, 1'b0, 8'h5A, 8'h33};
      repeat (3) @(posedge clock_in);
      rstn_in <= 1'b1;
      t_reset();
      t_freerun();
      conv(11'sh100, 4'h8, 11'sh100);
      conv(-11'sd100, 4'h8, -11'sd100);
      conv(11'sh100, 4'h9, 11'sh102);
      conv(11'sh100, 4'h0, 11'sh0F0);
      t_abort();
      conv(11'sh190, 4'h8, 11'sh190);
      t_standby_exit();
      t_fan();
      stop_test();
   end
endmodule
`default_nettype wire

// ===== tcs_diode_model.sv
// Behavioural remote sensing junction feeding the front-end sample
`timescale 1ns/100ps
`default_nettype none

module tcs_diode_model
(
   input  wire logic                clock_in,
   input  wire tcs_pkg::tcs_temp_t  temp_in,
   output var  tcs_pkg::tcs_temp_t  level_out
);
   import tcs_pkg::*;

   // Front end settles one clock after the junction changes
   always_ff @(posedge clock_in)
   begin
      level_out <= temp_in;
   end
endmodule
`default_nettype wire

// ===== tcs_integrator.sv
// Integrating converter core: averages samples over a fixed window
`timescale 1ns/100ps
`default_nettype none
`include "tcs_params.svh"

module tcs_integrator
#(
   parameter int unsigned WINDOW_CYCLES = `TCS_INTEGRATE_MS *
                                          `TCS_CYC_PER_MS_MHZ * `TCS_CLK_MHZ
)
(
   input  wire logic           clock_in,
   input  wire logic           rstn_in,
   input  wire logic           start_in,
   input  wire logic           abort_in,
   input  wire tcs_pkg::tcs_temp_t sample_in,
   output logic                busy_out,
   output logic                done_out,
   output tcs_pkg::tcs_temp_t  avg_out
);
   import tcs_pkg::*;

   localparam logic [31:0] RECIP =
      32'((64'(1) << `TCS_RECIP_SHIFT) / WINDOW_CYCLES);
   localparam logic [31:0] LAST = 32'(WINDOW_CYCLES - 1);

   logic signed [35:0] acc_q, acc_d;
   logic [31:0]        cnt_q, cnt_d;
   logic               busy_q, busy_d;
   logic               done_q, done_d;
   tcs_temp_t          avg_q, avg_d;
   logic signed [68:0] prod;

   always_comb
   begin
      acc_d  = acc_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      avg_d  = avg_q;
      prod   = '0;
      if (abort_in)
      begin
         busy_d = 1'b0;
         acc_d  = '0;
         cnt_d  = `TCS_COUNT_ZERO;
      end
      else if (start_in && !busy_q)
      begin
         busy_d = 1'b1;
         acc_d  = '0;
         cnt_d  = `TCS_COUNT_ZERO;
      end
      else if (busy_q)
      begin
         // Sum one sample per clock across the window
         acc_d = acc_q + $signed({{25{sample_in[10]}}, sample_in}); // R5
         cnt_d = cnt_q + `TCS_COUNT_ONE;
         if (cnt_q == LAST)
         begin
            busy_d = 1'b0;
            done_d = 1'b1;
            prod   = 69'(acc_d) * 69'($signed({1'b0, RECIP}));
            avg_d  = prod[42:32];
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
      begin
         acc_q  <= '0;
         cnt_q  <= `TCS_COUNT_ZERO;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         avg_q  <= `TCS_TEMP_RESET;
      end
      else
      begin
         acc_q  <= acc_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
         avg_q  <= avg_d;
      end
   end

   assign busy_out = busy_q;
   assign done_out = done_q;
   assign avg_out  = avg_q;

   property p_window;
      @(posedge clock_in) disable iff (!rstn_in)
      done_q |-> ($past(cnt_q) == LAST) && !busy_q;
   endproperty
   a_window_done_count: assert property (p_window) // R5
      else $error("window ended at wrong count");

endmodule
`default_nettype wire

// ===== tcs_params.svh
// Timing and field constants for the temperature conversion sequencer
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

`define TCS_CLK_MHZ        100
`define TCS_CYC_PER_MS_MHZ 1000
`define TCS_INTERVAL_MS    500
`define TCS_INTEGRATE_MS   125
`define TCS_RECIP_SHIFT    32
`define TCS_GAIN_MID       5'sh08
`define TCS_GAIN_SHIFT     7
`define TCS_RES_HI_LSB     3
`define TCS_FAN_LSB        2
`define TCS_LOW_PAD        5'h00
`define TCS_FAN_OFF        8'h00
`define TCS_FAN_FULL       8'hFF
`define TCS_TEMP_RESET     11'h000
`define TCS_COUNT_ZERO     32'h0000_0000
`define TCS_COUNT_ONE      32'h0000_0001

`endif

// ===== tcs_pkg.sv
// Types shared by the temperature conversion sequencer files
package tcs_pkg;

   typedef enum logic [0:0]
   {
      TCS_IDLE = 1'b0,
      TCS_CONV = 1'b1
   } tcs_state_e;

   // Signed result, ten magnitude bits plus sign, 0.125 C per LSB
   typedef logic signed [10:0] tcs_temp_t;

   typedef struct packed
   {
      logic signed [7:0] threshold;
      logic [2:0]        range_shift;
      logic              thermal_open;
      logic              speed_open;
      logic [7:0]        manual_speed;
      logic [7:0]        manual_drive;
   } tcs_fan_cfg_s;

   typedef struct packed
   {
      logic [7:0] high;
      logic [7:0] low;
   } tcs_bytes_s;

endpackage

// ===== tcs_sequencer.sv
// Temperature conversion sequencer with standby and fan target logic
// How it works
// R1 - Result is signed 11 bits, 0.125 C
// R2 - Free-run start every 500 ms outside standby
// R3 - Single conversion command starts conversion immediately
// R4 - Old result kept until conversion finishes
// R5 - Each conversion integrates input for 125 ms
// R6 - Standby stops converter, control loop, fan driver
// R7 - Standby retains stored values, commands still accepted; code drops a command on the standby entry cycle
// R8 - Command in standby runs one conversion; code runs none for a command on the standby entry cycle
// R9 - Four-bit gain field trims converter gain
// R10 - Fan target proportional above threshold, range
// R11 - Thermal or speed loop opened independently
// R12 - Standby entry aborts conversion, result kept
// R13 - High byte sign plus seven; low bits 7:5
// R14 - Host sends one-byte single conversion command
// R15 - Interval counter restarts on leaving standby
// R16 - Command ignored while conversion is running
`timescale 1ns/100ps
`default_nettype none
`include "tcs_params.svh"

module tcs_sequencer
#(
   parameter int unsigned INTERVAL_CYCLES = `TCS_INTERVAL_MS *
                                   `TCS_CYC_PER_MS_MHZ * `TCS_CLK_MHZ,
   parameter int unsigned WINDOW_CYCLES   = `TCS_INTEGRATE_MS *
                                   `TCS_CYC_PER_MS_MHZ * `TCS_CLK_MHZ
)
(
   input  wire logic                   clock_in,
   input  wire logic                   rstn_in,
   input  wire logic                   standby_in,
   input  wire logic                   single_conversion_command_in,
   input  wire logic [3:0]             gain_trim_in,
   input  wire tcs_pkg::tcs_temp_t     adc_level_in,
   input  wire tcs_pkg::tcs_fan_cfg_s  fan_cfg_in,
   output tcs_pkg::tcs_temp_t          temp_result_out,
   output tcs_pkg::tcs_bytes_s         temp_bytes_out,
   output logic                        result_update_out,
   output logic                        converting_out,
   output logic                        standby_out,
   output logic [7:0]                  fan_target_out,
   output logic [7:0]                  fan_drive_out
);
   import tcs_pkg::*;

   localparam logic [31:0] INT_LAST = 32'(INTERVAL_CYCLES - 1);

   // Gain trim: step of 1/128 around a mid code, saturated to 11 bits
   function automatic tcs_temp_t gain_apply(input tcs_temp_t avg,
                                            input logic [3:0] trim);
      logic signed [4:0]  delta;
      logic signed [15:0] scaled;
      logic signed [12:0] sum;
      delta  = $signed({1'b0, trim}) - `TCS_GAIN_MID;
      scaled = (16'(avg) * 16'(delta)) >>> `TCS_GAIN_SHIFT;
      sum    = 13'(avg) + 13'(scaled);
      if (sum > 13'sd1023)
         gain_apply = 11'sd1023;
      else if (sum < -13'sd1024)
         gain_apply = -11'sd1024;
      else
         gain_apply = sum[10:0];
   endfunction

   // Fan level from half-degree temperature over a threshold
   function automatic logic [7:0] fan_level(input tcs_temp_t temp,
                                            input tcs_fan_cfg_s cfg);
      logic signed [9:0] diff;
      logic [16:0]       span;
      diff = $signed({temp[10], temp[10:`TCS_FAN_LSB]})
           - $signed({cfg.threshold[7], cfg.threshold, 1'b0});
      span = 17'(diff[8:0]) << cfg.range_shift;
      if (diff <= 10'sd0)
         fan_level = `TCS_FAN_OFF;
      else if (span > 17'(`TCS_FAN_FULL))
         fan_level = `TCS_FAN_FULL;
      else
         fan_level = span[7:0];
   endfunction

   tcs_state_e  state_q, state_d;
   logic [31:0] int_q, int_d;
   logic        stby_q;
   logic        conv_q, conv_d;
   logic        upd_q, upd_d;
   tcs_temp_t   result_q, result_d;
   tcs_bytes_s  bytes_q, bytes_d;
   logic [7:0]  target_q, target_d;
   logic [7:0]  drive_q, drive_d;
   logic        tick;
   logic        enter_stby;
   logic        abort;
   logic        start;
   logic        intg_busy;
   logic        intg_done;
   tcs_temp_t   intg_avg;

   tcs_integrator
   #(
      .WINDOW_CYCLES (WINDOW_CYCLES)
   )
   u_integrator
   (
      .clock_in  (clock_in),
      .rstn_in   (rstn_in),
      .start_in  (start),
      .abort_in  (abort),
      .sample_in (adc_level_in),
      .busy_out  (intg_busy),
      .done_out  (intg_done),
      .avg_out   (intg_avg)
   );

   // Interval and start decisions
   always_comb
   begin
      tick       = !standby_in && (int_q == INT_LAST); // R2
      enter_stby = standby_in && !stby_q;
      abort      = enter_stby && (state_q == TCS_CONV); // R12
      // Commands accepted in standby after its entry cycle; ignored while busy or on standby entry
      start      = (state_q == TCS_IDLE) && !enter_stby
                 && (single_conversion_command_in || tick); // R3 R8 R16
      if (standby_in || tick)
         int_d = `TCS_COUNT_ZERO; // R15
      else
         int_d = int_q + `TCS_COUNT_ONE;
   end

   // Conversion state and result publishing
   always_comb
   begin
      state_d  = state_q;
      upd_d    = 1'b0;
      result_d = result_q; // R4 R7
      case (state_q)
         TCS_IDLE:
         begin
            if (start)
               state_d = TCS_CONV;
         end
         TCS_CONV:
         begin
            if (abort)
               state_d = TCS_IDLE; // R12
            else if (intg_done)
            begin
               state_d  = TCS_IDLE;
               upd_d    = 1'b1;
               result_d = gain_apply(intg_avg, gain_trim_in); // R1 R9
            end
         end
         default:
            state_d = TCS_IDLE;
      endcase
      conv_d       = (state_d == TCS_CONV);
      bytes_d.high = result_d[10:`TCS_RES_HI_LSB]; // R13
      bytes_d.low  = {result_d[2:0], `TCS_LOW_PAD}; // R13
   end

   // Fan target and driver; frozen or off in standby
   always_comb
   begin
      target_d = target_q;
      drive_d  = `TCS_FAN_OFF;
      if (!standby_in) // R6
      begin
         if (fan_cfg_in.thermal_open)
            target_d = fan_cfg_in.manual_speed; // R11
         else
            target_d = fan_level(result_q, fan_cfg_in); // R10
         if (fan_cfg_in.speed_open)
            drive_d = fan_cfg_in.manual_drive; // R11
         else
            drive_d = target_d;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
      begin
         state_q  <= TCS_IDLE;
         int_q    <= `TCS_COUNT_ZERO;
         stby_q   <= 1'b0;
         conv_q   <= 1'b0;
         upd_q    <= 1'b0;
         result_q <= `TCS_TEMP_RESET;
         bytes_q  <= '0;
         target_q <= `TCS_FAN_OFF;
         drive_q  <= `TCS_FAN_OFF;
      end
      else
      begin
         state_q  <= state_d;
         int_q    <= int_d;
         stby_q   <= standby_in;
         conv_q   <= conv_d;
         upd_q    <= upd_d;
         result_q <= result_d;
         bytes_q  <= bytes_d;
         target_q <= target_d;
         drive_q  <= drive_d;
      end
   end

   assign temp_result_out   = result_q;
   assign temp_bytes_out    = bytes_q;
   assign result_update_out = upd_q;
   assign converting_out    = conv_q;
   assign standby_out       = stby_q;
   assign fan_target_out    = target_q;
   assign fan_drive_out     = drive_q;

   sequence s_idle_cmd;
      single_conversion_command_in && (state_q == TCS_IDLE)
      && !enter_stby;
   endsequence

   sequence s_abort_seen;
      enter_stby && converting_out;
   endsequence

   a_cmd_starts: assert property ( // R3
      @(posedge clock_in) disable iff (!rstn_in)
      s_idle_cmd |=> converting_out && !result_update_out)
      else $error("command did not start conversion");

   a_standby_cmd: assert property ( // R8
      @(posedge clock_in) disable iff (!rstn_in)
      (stby_q && standby_in) and s_idle_cmd |=> converting_out)
      else $error("command in standby did not convert");

   a_result_hold: assert property ( // R4
      @(posedge clock_in) disable iff (!rstn_in)
      !result_update_out |-> $stable(temp_result_out))
      else $error("result changed without completion");

   a_abort_keep: assert property ( // R12
      @(posedge clock_in) disable iff (!rstn_in)
      s_abort_seen |=> !converting_out && !result_update_out
                       && $stable(temp_result_out) && !intg_busy)
      else $error("standby entry did not abort cleanly");

   a_busy_ignore: assert property ( // R16
      @(posedge clock_in) disable iff (!rstn_in)
      converting_out && single_conversion_command_in && !intg_done
      && !enter_stby |=> converting_out && (intg_busy || intg_done))
      else $error("command disturbed running conversion");

   a_interval_tick: assert property ( // R2
      @(posedge clock_in) disable iff (!rstn_in)
      (int_q == INT_LAST) && !standby_in && (state_q == TCS_IDLE)
      |=> converting_out && (int_q == `TCS_COUNT_ZERO))
      else $error("interval expiry did not start conversion");

   a_standby_restart: assert property ( // R15
      @(posedge clock_in) disable iff (!rstn_in)
      $fell(standby_out) |-> (int_q == `TCS_COUNT_ONE)
      ##1 ((int_q > `TCS_COUNT_ONE) || standby_out))
      else $error("interval did not restart after standby");

   a_standby_fan: assert property ( // R6
      @(posedge clock_in) disable iff (!rstn_in)
      standby_out |-> (fan_drive_out == `TCS_FAN_OFF)
                      && $stable(fan_target_out))
      else $error("fan active in standby");

   a_byte_map: assert property ( // R13
      @(posedge clock_in) disable iff (!rstn_in)
      (temp_bytes_out.high == temp_result_out[10:3])
      && (temp_bytes_out.low == {temp_result_out[2:0], 5'h00}))
      else $error("temperature bytes mismatch result");

   a_fan_floor: assert property ( // R10
      @(posedge clock_in) disable iff (!rstn_in)
      !standby_in && !fan_cfg_in.thermal_open
      && ($signed(temp_result_out[10:2])
          <= $signed({fan_cfg_in.threshold, 1'b0}))
      |=> fan_target_out == `TCS_FAN_OFF)
      else $error("fan target not zero below threshold");

   a_loop_open: assert property ( // R11
      @(posedge clock_in) disable iff (!rstn_in)
      !standby_in && fan_cfg_in.thermal_open && fan_cfg_in.speed_open
      |=> (fan_target_out == $past(fan_cfg_in.manual_speed))
          && (fan_drive_out == $past(fan_cfg_in.manual_drive)))
      else $error("open loop value not followed");

   a_update_ends: assert property ( // R4
      @(posedge clock_in) disable iff (!rstn_in)
      result_update_out |-> !converting_out && !intg_busy)
      else $error("update while still converting");

   a_drive_follow: assert property ( // R10
      @(posedge clock_in) disable iff (!rstn_in)
      !standby_in && !fan_cfg_in.speed_open
      |=> fan_drive_out == fan_target_out)
      else $error("fan drive not following target");

   a_standby_idle: assert property ( // R6
      @(posedge clock_in) disable iff (!rstn_in)
      standby_in && !converting_out && !single_conversion_command_in
      |=> !converting_out)
      else $error("conversion started in standby without command");

endmodule
`default_nettype wire
